// File: sdf_pkg.sv
// constants shared by the sigma-delta filter and calibration block
`default_nettype none
package sdf_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_FILTER = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_DATA0 = 8'h0C;
	localparam logic [7:0] ADDR_DATA1 = 8'h10;
	localparam logic [7:0] ADDR_OFS0 = 8'h14;
	localparam logic [7:0] ADDR_GAIN0 = 8'h18;
	localparam logic [7:0] ADDR_OFS1 = 8'h1C;
	localparam logic [7:0] ADDR_GAIN1 = 8'h20;
	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int DW = 24;
	localparam int MODE_EN0_BIT = 4;
	localparam int MODE_EN1_BIT = 5;
	localparam int STAT_RDY0_BIT = 0;
	localparam int STAT_PRIMARY_CHANNEL_ERROR_FLAG_BIT = 2;
	localparam int STAT_NOREF_BIT = 4;
	localparam int STAT_BUSY_BIT = 5;
	localparam logic [7:0] FILT_RST = 8'h45;
	localparam logic [7:0] FILT_MIN = 8'h0D;
	localparam logic [7:0] FILT_SLOW = 8'hFF;
	localparam int DEC_SHIFT = 3;
	localparam int OUT_LSB = 9;
	localparam int ACC_W = 34;
	// ----------------------------------------
	// calibration arithmetic
	// ----------------------------------------
	localparam int GAIN_FRAC = 22;
	localparam logic [23:0] GAIN_ONE = 24'h40_0000;
	localparam logic [23:0] FS_SPAN = 24'hFF_FFFF;
	localparam logic [23:0] GAIN_MIN_DEN = 24'h40_0000;
	localparam logic [23:0] DATA_ALL_ONES = 24'hFF_FFFF;
	localparam logic [4:0] DIV_LAST = 5'h17;
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_IDLE,
		MODE_SINGLE,
		MODE_CONT,
		MODE_INT_ZERO,
		MODE_INT_FULL,
		MODE_SYS_ZERO,
		MODE_SYS_FULL
	} sdf_mode_t;
endpackage
`default_nettype wire

// File: sdf_sinc3.sv
// third-order sinc decimator for one modulator bit stream
`timescale 1ns/1ps
`default_nettype none
module sdf_sinc3
	import sdf_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// control
	input wire logic i_restart,
	input wire logic [7:0] i_ratio,
	// stream in, words out
	input wire logic i_bit,
	output logic [DW-1:0] o_word,
	output logic o_valid
);
	logic [ACC_W-1:0] int1_r, int2_r, int3_r;
	logic [ACC_W-1:0] d1_r, d2_r, d3_r;
	logic [ACC_W-1:0] c1, c2, c3;
	logic [10:0] cnt_r;
	logic [10:0] last;

	// decimation is the word times eight
	assign last = 11'({i_ratio, 3'b000} - 11'h001);
	// wrap-around arithmetic is intended: combs undo integrator overflow
	assign c1 = int3_r - d1_r;
	assign c2 = c1 - d2_r;
	assign c3 = c2 - d3_r;

	// ----------------------------------------
	// integrators and decimation
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			int1_r <= '0;
			int2_r <= '0;
			int3_r <= '0;
			cnt_r <= '0;
		end
		else if (i_restart)
		begin
			int1_r <= '0;
			int2_r <= '0;
			int3_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			int1_r <= int1_r + ACC_W'(i_bit);
			int2_r <= int2_r + int1_r;
			int3_r <= int3_r + int2_r;
			cnt_r <= (cnt_r >= last) ? '0 : 11'(cnt_r + 11'h001);
		end
	end

	// ----------------------------------------
	// combs at the output rate
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			d1_r <= '0;
			d2_r <= '0;
			d3_r <= '0;
			o_word <= '0;
			o_valid <= 1'b0;
		end
		else if (i_restart)
		begin
			d1_r <= '0;
			d2_r <= '0;
			d3_r <= '0;
			o_valid <= 1'b0;
		end
		else
		begin
			o_valid <= (cnt_r >= last);
			if (cnt_r >= last)
			begin
				d1_r <= int3_r;
				d2_r <= c1;
				d3_r <= c2;
				o_word <= c3[OUT_LSB+DW-1:OUT_LSB];
			end
		end
	end
endmodule
`default_nettype wire

// File: sdf_top.sv
// two-channel sigma-delta back end: sinc3, chop averaging, calibration, apb
//
// Overview of operation
// R1: each filter takes the synchronised one-bit modulator stream and makes multi-bit words
// R2: sinc3 decimator; decimation and output rate set by the filter rate word
// R3: filter rate word resets to 45 hex, just under 20 Hz
// R4: filter rate word accepts 13 to 255; smaller writes clamp to 13
// R5: each channel reverses its input polarity every output period
// R6: each new filter word is averaged with the previous one
// R7: first result after two output periods, then one per period
// R8: mode register selects four calibration modes and per-channel enables
// R9: offset and gain registers load factory coefficients at reset
// R10: a channel calibrates only while its enable bit is set
// R11: zero-scale calibration stores its conversion as the offset coefficient
// R12: full-scale calibration stores its conversion as the gain coefficient; code stores FS_SPAN times GAIN_ONE over (conversion minus offset)
// R13: internal calibration routes zero or full-scale onto the modulator input
// R14: software applies system zero or full-scale to pins before system calibration
// R15: calibration always runs at the slowest filter rate
// R16: offset subtracted first, then multiplied by the normalised gain
// R17: software should run zero-scale before full-scale calibration
// R18: channel ready flag marks the end of a calibration too
// R19: missing reference during calibration blocks coefficient update, sets error flag
// R20: missing reference forces conversion results to all ones
// R21: ready flag sets whenever a new result enters the data register
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sdf_top
	import sdf_pkg::*;
#(
	parameter logic [23:0] P_OFS0_FACTORY = 24'h00_0000,
	parameter logic [23:0] P_GAIN0_FACTORY = 24'h40_0000,
	parameter logic [23:0] P_OFS1_FACTORY = 24'h00_0000,
	parameter logic [23:0] P_GAIN1_FACTORY = 24'h40_0000
)
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// modulators and reference detect
	input wire logic [1:0] i_mod_bit,
	input wire logic i_ref_missing,
	output logic [1:0] o_chop,
	output logic [1:0] o_cal_zero,
	output logic [1:0] o_cal_full
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [DW-1:0] f_avg(input logic [DW-1:0] a, input logic [DW-1:0] b);
		logic [DW:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[DW:1];
	endfunction

	function automatic logic [DW-1:0] f_correct(input logic [DW-1:0] v,
		input logic [DW-1:0] ofs, input logic [DW-1:0] g);
		logic signed [DW:0] diff;
		logic signed [2*DW+1:0] prod;
		logic signed [2*DW+1:0] sh;
		diff = $signed({1'b0, v}) - $signed({1'b0, ofs});
		prod = (2*DW+2)'(diff * $signed({1'b0, g}));
		sh = prod >>> GAIN_FRAC;
		if (sh < 0)
			return '0;
		else if (sh > $signed({2'b00, 24'h00_0000, FS_SPAN}))
			return FS_SPAN;
		else
			return sh[DW-1:0];
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] filt_r;
	logic [2:0] mode_r;
	logic [1:0] en_r;
	logic restart_r;
	logic [1:0] mod_s1_r, mod_s2_r;
	logic ref_s1_r, ref_s2_r;
	logic [1:0] chop_r, have_prev_r;
	logic [1:0] chop_d1_r, chop_d2_r;
	logic [DW-1:0] prev_r [2];
	logic [DW-1:0] data_r [2];
	logic [DW-1:0] ofs_r [2];
	logic [DW-1:0] gain_r [2];
	logic [1:0] rdy_r, err_r, done_r, ref_lost_r;
	logic [1:0] div_busy_r;
	logic [4:0] div_cnt_r [2];
	logic [47:0] div_rem_r [2];
	logic [47:0] div_den_r [2];
	logic [DW-1:0] div_q_r [2];
	logic [DW-1:0] f_word [2];
	logic [1:0] f_valid, f_restart, run;
	logic [DW-1:0] avg [2];
	logic [1:0] ev, conv_ev, zero_ok, cal_bad, full_go, div_fin;
	logic cal_act, conv_act, is_zero, is_int, all_done;
	logic [7:0] ratio;
	logic wr, rd;
	logic [1:0] rd_data;
	logic [31:0] rdata;
	logic mapped;

	assign wr = i_psel & i_penable & i_pwrite & ~o_pready;
	assign rd = i_psel & i_penable & ~i_pwrite & ~o_pready;
	assign cal_act = mode_r >= 3'(MODE_INT_ZERO); // R8
	assign conv_act = (mode_r == 3'(MODE_SINGLE)) | (mode_r == 3'(MODE_CONT));
	assign is_zero = (mode_r == 3'(MODE_INT_ZERO)) | (mode_r == 3'(MODE_SYS_ZERO));
	assign is_int = (mode_r == 3'(MODE_INT_ZERO)) | (mode_r == 3'(MODE_INT_FULL));
	assign ratio = cal_act ? FILT_SLOW : filt_r; // R15
	assign all_done = &(done_r | ~en_r);
	assign rd_data[0] = rd & (i_paddr == ADDR_DATA0);
	assign rd_data[1] = rd & (i_paddr == ADDR_DATA1);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			mod_s1_r <= '0;
			mod_s2_r <= '0;
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
		end
		else
		begin
			mod_s1_r <= i_mod_bit;
			mod_s2_r <= mod_s1_r;
			ref_s1_r <= i_ref_missing;
			ref_s2_r <= ref_s1_r;
		end
	end

	// ----------------------------------------
	// filters and per-channel events
	// ----------------------------------------
	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		// undo the chop digitally so each word carries +offset then -offset
		sdf_sinc3 u_sinc3 (
			.i_core_clk(i_core_clk),
			.i_reset_n(i_reset_n),
			.i_restart(f_restart[c]),
			.i_ratio(ratio),
			.i_bit(mod_s2_r[c] ^ chop_d2_r[c]), // R1 R2
			.o_word(f_word[c]),
			.o_valid(f_valid[c])
		);
		assign run[c] = en_r[c] & (conv_act | (cal_act & ~done_r[c])); // R10
		assign f_restart[c] = restart_r | ~run[c];
		assign avg[c] = f_avg(f_word[c], prev_r[c]); // R6
		assign ev[c] = run[c] & f_valid[c] & have_prev_r[c]; // R7
		assign conv_ev[c] = ev[c] & conv_act;
		assign zero_ok[c] = ev[c] & cal_act & is_zero & ~ref_lost_r[c] & ~ref_s2_r;
		assign full_go[c] = ev[c] & cal_act & ~is_zero & ~ref_lost_r[c] & ~ref_s2_r
			& (avg[c] > ofs_r[c]) & ((avg[c] - ofs_r[c]) >= GAIN_MIN_DEN);
		assign cal_bad[c] = ev[c] & cal_act & ~zero_ok[c] & ~full_go[c];
		assign div_fin[c] = div_busy_r[c] & (div_cnt_r[c] == 5'h00);
	end

	// ----------------------------------------
	// chop and averaging pipeline
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			chop_r <= '0;
			have_prev_r <= '0;
			prev_r <= '{default: '0};
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (f_restart[c])
				begin
					chop_r[c] <= 1'b0;
					have_prev_r[c] <= 1'b0;
				end
				else if (f_valid[c])
				begin
					chop_r[c] <= ~chop_r[c]; // R5
					have_prev_r[c] <= 1'b1; // R7
					prev_r[c] <= f_word[c];
				end
			end
		end
	end

	// ----------------------------------------
	// analog routing outputs
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_chop <= '0;
			chop_d1_r <= '0;
			chop_d2_r <= '0;
			o_cal_zero <= '0;
			o_cal_full <= '0;
		end
		else
		begin
			o_chop <= chop_r;
			// undo lags like the stream: output flop plus two sync stages
			chop_d1_r <= o_chop; // R5
			chop_d2_r <= chop_d1_r;
			o_cal_zero <= (is_int & is_zero) ? run : 2'b00; // R13
			o_cal_full <= (is_int & ~is_zero) ? run : 2'b00; // R13
		end
	end

	// ----------------------------------------
	// data registers
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			data_r <= '{default: '0};
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (conv_ev[c])
					data_r[c] <= ref_s2_r ? DATA_ALL_ONES : // R20
						f_correct(avg[c], ofs_r[c], gain_r[c]); // R16
			end
		end
	end

	// ----------------------------------------
	// coefficients and gain divider
	// ----------------------------------------
	// the divider turns a full-scale reading into a gain with one at GAIN_ONE
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ofs_r[0] <= P_OFS0_FACTORY; // R9
			gain_r[0] <= P_GAIN0_FACTORY; // R9
			ofs_r[1] <= P_OFS1_FACTORY; // R9
			gain_r[1] <= P_GAIN1_FACTORY; // R9
			div_busy_r <= '0;
			div_cnt_r <= '{default: '0};
			div_rem_r <= '{default: '0};
			div_den_r <= '{default: '0};
			div_q_r <= '{default: '0};
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (wr & (i_paddr == (c == 0 ? ADDR_OFS0 : ADDR_OFS1)))
					ofs_r[c] <= i_pwdata[DW-1:0];
				else if (zero_ok[c])
					ofs_r[c] <= avg[c]; // R11 R19
				if (wr & (i_paddr == (c == 0 ? ADDR_GAIN0 : ADDR_GAIN1)))
					gain_r[c] <= i_pwdata[DW-1:0];
				else if (div_fin[c])
					// quotient bit zero is only decided in this cycle
					gain_r[c] <= {div_q_r[c][DW-1:1], div_rem_r[c] >= div_den_r[c]}; // R12 R16
				if (full_go[c])
				begin
					div_busy_r[c] <= 1'b1; // R19
					div_cnt_r[c] <= DIV_LAST;
					div_rem_r[c] <= {2'b00, FS_SPAN, 22'h00_0000};
					div_den_r[c] <= {24'h00_0000, 24'(avg[c] - ofs_r[c])};
					div_q_r[c] <= '0;
				end
				else if (div_busy_r[c])
				begin
					if (div_rem_r[c] >= (div_den_r[c] << div_cnt_r[c]))
					begin
						div_rem_r[c] <= div_rem_r[c] - (div_den_r[c] << div_cnt_r[c]);
						div_q_r[c][div_cnt_r[c]] <= 1'b1;
					end
					div_cnt_r[c] <= 5'(div_cnt_r[c] - 5'h01);
					if (div_fin[c])
						div_busy_r[c] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// ready, error and calibration progress
	// ----------------------------------------
	// new ready and error events win over a clear in the same cycle; for done_r the clear wins
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rdy_r <= '0;
			err_r <= '0;
			done_r <= '0;
			ref_lost_r <= '0;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (conv_ev[c] | zero_ok[c] | cal_bad[c] | div_fin[c])
					rdy_r[c] <= 1'b1; // R18 R21
				else if (rd_data[c])
					rdy_r[c] <= 1'b0;
				if (cal_bad[c])
					err_r[c] <= 1'b1; // R19
				else if (wr & (i_paddr == ADDR_STATUS) & i_pwdata[STAT_PRIMARY_CHANNEL_ERROR_FLAG_BIT+c])
					err_r[c] <= 1'b0;
				if (!cal_act)
					ref_lost_r[c] <= 1'b0;
				else if (ref_s2_r)
					ref_lost_r[c] <= 1'b1; // R19
				if (!cal_act | restart_r)
					done_r[c] <= 1'b0;
				else if (zero_ok[c] | cal_bad[c] | div_fin[c])
					done_r[c] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// filter rate word and mode register
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			filt_r <= FILT_RST; // R3
			mode_r <= 3'(MODE_OFF);
			en_r <= '0;
			restart_r <= 1'b0;
		end
		else
		begin
			restart_r <= wr & ((i_paddr == ADDR_FILTER) | (i_paddr == ADDR_MODE)); // R7
			if (wr & (i_paddr == ADDR_FILTER))
				filt_r <= (i_pwdata[7:0] < FILT_MIN) ? FILT_MIN : i_pwdata[7:0]; // R4
			if (wr & (i_paddr == ADDR_MODE))
			begin
				mode_r <= i_pwdata[2:0]; // R8
				en_r <= {i_pwdata[MODE_EN1_BIT], i_pwdata[MODE_EN0_BIT]}; // R8
			end
			else if (cal_act & all_done & ~|div_busy_r)
				mode_r <= 3'(MODE_IDLE);
			else if ((mode_r == 3'(MODE_SINGLE)) & |conv_ev)
				mode_r <= 3'(MODE_IDLE);
		end
	end

	// ----------------------------------------
	// apb read mux and answer
	// ----------------------------------------
	always_comb
	begin
		rdata = '0;
		mapped = 1'b1;
		case (i_paddr)
			ADDR_FILTER: rdata[7:0] = filt_r;
			ADDR_MODE: rdata[5:0] = {en_r, 1'b0, mode_r};
			ADDR_STATUS:
			begin
				rdata[STAT_RDY0_BIT+1:STAT_RDY0_BIT] = rdy_r;
				rdata[STAT_PRIMARY_CHANNEL_ERROR_FLAG_BIT+1:STAT_PRIMARY_CHANNEL_ERROR_FLAG_BIT] = err_r;
				rdata[STAT_NOREF_BIT] = ref_s2_r;
				rdata[STAT_BUSY_BIT] = cal_act;
			end
			ADDR_DATA0: rdata[DW-1:0] = data_r[0];
			ADDR_DATA1: rdata[DW-1:0] = data_r[1];
			ADDR_OFS0: rdata[DW-1:0] = ofs_r[0];
			ADDR_GAIN0: rdata[DW-1:0] = gain_r[0];
			ADDR_OFS1: rdata[DW-1:0] = ofs_r[1];
			ADDR_GAIN1: rdata[DW-1:0] = gain_r[1];
			default: mapped = 1'b0;
		endcase
	end

	// one wait state keeps the read mux off the bus critical path
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= '0;
		end
		else
		begin
			o_pready <= i_psel & i_penable & ~o_pready;
			o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
			if (rd)
				o_prdata <= rdata;
		end
	end
endmodule
`default_nettype wire

// File: sdf_mod_model.sv
// modulator stand-in: one bit per clock for each channel
`timescale 1ns/1ps
`default_nettype none
module sdf_mod_model
(
	// clock and steering from the block
	input wire logic i_core_clk,
	input wire logic [1:0] i_cal_zero,
	input wire logic [1:0] i_cal_full,
	input wire logic [1:0] i_chop,
	// pin level per channel: 1 full scale, 0 zero scale
	input wire logic [1:0] i_level,
	// bit streams
	output logic [1:0] o_bit
);
	logic [1:0] lvl_r = 2'b00;
	// polarity reversal acts at once on the comparator output
	assign o_bit = lvl_r ^ i_chop;
	always @(posedge i_core_clk)
	begin
		for (int c = 0; c < 2; c++)
		begin
			if (i_cal_full[c])
				lvl_r[c] <= 1'b1;
			else if (i_cal_zero[c])
				lvl_r[c] <= 1'b0;
			else
				lvl_r[c] <= i_level[c];
		end
	end
endmodule
`default_nettype wire

// File: sdf_top_sva.sv
// port assertions for the sigma-delta back end
`timescale 1ns/1ps
`default_nettype none
module sdf_top_sva
	import sdf_pkg::*;
(
	// watched ports
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [1:0] o_cal_zero,
	input wire logic [1:0] o_cal_full
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	logic [5:0] mode_w;
	logic [5:0] mode_d;
	logic [5:0] mode_dd;
	logic [12:0] zero_len;
	logic bad_addr;
	assign bad_addr = (i_paddr > ADDR_GAIN1) || (i_paddr[1:0] != 2'b00);
	// two delayed copies: the routing outputs lag a mode write
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			mode_w <= '0;
			mode_d <= '0;
			mode_dd <= '0;
		end
		else
		begin
			if (i_psel && i_penable && i_pwrite && !o_pready && i_paddr == ADDR_MODE)
				mode_w <= i_pwdata[5:0];
			mode_d <= mode_w;
			mode_dd <= mode_d;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			zero_len <= '0;
		else
			zero_len <= o_cal_zero[0] ? zero_len + 13'h1 : 13'h0;
	end
	chk_ready_once: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
	chk_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("ready late");
	chk_err_addr: assert property (o_pready |-> o_pslverr == bad_addr) else $error("slave error wrong");
	chk_err_alone: assert property (o_pslverr |-> o_pready) else $error("slave error without ready");
	chk_rdata_read: assert property ($changed(o_prdata) |-> o_pready && !i_pwrite) else $error("read data moved");
	chk_quiet_reset: assert property ($rose(i_reset_n) |-> !o_pready && o_cal_zero == 2'b00) else $error("busy at reset");
	chk_cal_en0: assert property (o_cal_zero[0] || o_cal_full[0] |-> mode_w[4] || mode_d[4] || mode_dd[4])
		else $error("disabled channel 0 calibrates");
	chk_cal_en1: assert property (o_cal_zero[1] || o_cal_full[1] |-> mode_w[5] || mode_d[5] || mode_dd[5])
		else $error("disabled channel 1 calibrates");
	chk_zero_code: assert property (|o_cal_zero |-> mode_w[2:0] == 3'd4 || mode_d[2:0] == 3'd4 || mode_dd[2:0] == 3'd4)
		else $error("zero routing in wrong mode");
	chk_full_code: assert property (|o_cal_full |-> mode_w[2:0] == 3'd5 || mode_d[2:0] == 3'd5 || mode_dd[2:0] == 3'd5)
		else $error("full routing in wrong mode");
	chk_cal_slow: assert property ($fell(o_cal_zero[0]) |-> zero_len >= 13'd4080)
		else $error("calibration too short");
	cover property (o_cal_zero[0]);
	cover property (o_cal_full[1]);
	cover property (o_pready && o_pslverr);
endmodule
bind sdf_top sdf_top_sva sdf_top_sva_inst (.i_core_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_cal_zero, .o_cal_full);
`default_nettype wire

// File: sdf_top_tb_top.sv
// self-checking bench for the sigma-delta back end
`timescale 1ns/1ps
`default_nettype none
module sdf_top_tb_top
	import sdf_pkg::*;
;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} sdf_row_t;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic ref_missing = 1'b0;
	logic [1:0] level = 2'b00;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] mod_bit;
	logic [1:0] chop;
	logic [1:0] cal_zero;
	logic [1:0] cal_full;
	logic chop_q = 1'b0;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int chop_n = 0;
	sdf_row_t rows[16] = '{
		'{1'b0, ADDR_FILTER, 32'h0, 32'h45, 1'b0},
		'{1'b0, ADDR_OFS0, 32'h0, 32'h100, 1'b0},
		'{1'b0, ADDR_GAIN0, 32'h0, 32'h41_0000, 1'b0},
		'{1'b0, ADDR_OFS1, 32'h0, 32'h200, 1'b0},
		'{1'b0, ADDR_GAIN1, 32'h0, 32'h42_0000, 1'b0},
		'{1'b0, ADDR_MODE, 32'h0, 32'h0, 1'b0},
		'{1'b1, ADDR_FILTER, 32'h0C, 32'h0, 1'b0},
		'{1'b0, ADDR_FILTER, 32'h0, 32'h0D, 1'b0},
		'{1'b1, ADDR_FILTER, 32'hFF, 32'h0, 1'b0},
		'{1'b0, ADDR_FILTER, 32'h0, 32'hFF, 1'b0},
		'{1'b1, 8'h24, 32'h55, 32'h0, 1'b1},
		'{1'b0, 8'h24, 32'h0, 32'h0, 1'b1},
		'{1'b1, ADDR_DATA0, 32'h77, 32'h0, 1'b0},
		'{1'b0, ADDR_DATA0, 32'h0, 32'h0, 1'b0},
		'{1'b1, ADDR_GAIN1, 32'h12_3456, 32'h0, 1'b0},
		'{1'b0, ADDR_GAIN1, 32'h0, 32'h12_3456, 1'b0}};
	sdf_top #(.P_OFS0_FACTORY(24'h00_0100), .P_GAIN0_FACTORY(24'h41_0000), .P_OFS1_FACTORY(24'h00_0200),
		.P_GAIN1_FACTORY(24'h42_0000)) sdf_top_inst (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_mod_bit(mod_bit), .i_ref_missing(ref_missing), .o_chop(chop),
		.o_cal_zero(cal_zero), .o_cal_full(cal_full));
	sdf_mod_model sdf_mod_model_inst (.i_core_clk(core_clk), .i_cal_zero(cal_zero), .i_cal_full(cal_full),
		.i_chop(chop), .i_level(level), .o_bit(mod_bit));
	initial
		forever #12.5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc++;
		if (chop[0] !== chop_q)
		begin
			chop_q = chop[0];
			chop_n++;
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic chk_rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		num_checks++;
		if (((v >= lo) && (v <= hi)) !== 1'b1)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
		end
	endtask
	// status polling; a bounded count keeps a stuck flag from hanging the run
	task automatic wait_st(input logic [31:0] m, output int t);
		logic [31:0] s;
		int k;
		k = 0;
		s = 32'h0;
		while ((s & m) !== m && k < 3000)
		begin
			rd(ADDR_STATUS, s);
			k++;
		end
		t = cyc;
		if (k >= 3000)
			n_errors++;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		results();
	end
	initial
	begin
		logic [31:0] d;
		logic [7:0] a;
		logic e;
		int t0;
		int t1;
		int c1;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i].wr, rows[i].a, rows[i].d, d, e);
			chk({31'h0, e}, {31'h0, rows[i].e});
			if (!rows[i].wr)
				chk(d, rows[i].x);
		end
		$display("done registers");
		wr(ADDR_FILTER, 32'h0D);
		wr(ADDR_MODE, 32'h13);
		t0 = cyc;
		wait_st(32'h1, t1);
		chk_rng(32'(t1 - t0), 32'd200, 32'd248);
		rd(ADDR_DATA0, d);
		chk(d, 32'h0);
		c1 = chop_n;
		rd(ADDR_STATUS, d);
		chk(d & 32'h1, 32'h0);
		t0 = t1;
		wait_st(32'h1, t1);
		chk_rng(32'(t1 - t0), 32'd92, 32'd116);
		chk(32'(chop_n - c1), 32'h1);
		ref_missing <= 1'b1;
		rd(ADDR_DATA0, d);
		wait_st(32'h11, t1);
		rd(ADDR_DATA0, d);
		chk(d, 32'hFF_FFFF);
		ref_missing <= 1'b0;
		wr(ADDR_MODE, 32'h12);
		wait_st(32'h1, t1);
		rd(ADDR_MODE, d);
		chk(d, 32'h11);
		wr(ADDR_MODE, 32'h0);
		$display("done conversion");
		// zero scale ahead of full scale, internal pair then system pair
		for (int m = 4; m < 8; m++)
		begin
			level <= (m == 7) ? 2'b11 : 2'b00;
			rd(ADDR_DATA0, d);
			rd(ADDR_DATA1, d);
			wr(ADDR_MODE, 32'h30 | 32'(m));
			t0 = cyc;
			wait_st(32'h3, t1);
			chk_rng(32'(t1 - t0), 32'd4080, 32'd4400);
			rd(ADDR_STATUS, d);
			chk(d & 32'hC, 32'h0);
			for (int ch = 0; ch < 2; ch++)
			begin
				a = (ch == 1 ? ADDR_OFS1 : ADDR_OFS0) + 8'(4 * (m % 2));
				rd(a, d);
				if (m % 2 == 1)
					chk_rng(d, 32'h80_0000, 32'h83_0000);
				else
					chk(d, 32'h0);
			end
		end
		$display("done calibration");
		wr(ADDR_OFS0, 32'h777);
		wr(ADDR_OFS1, 32'h555);
		level <= 2'b10;
		ref_missing <= 1'b1;
		rd(ADDR_DATA0, d);
		wr(ADDR_MODE, 32'h14);
		wait_st(32'h1, t1);
		rd(ADDR_STATUS, d);
		chk(d & 32'h5, 32'h5);
		rd(ADDR_OFS0, d);
		chk(d, 32'h777);
		rd(ADDR_OFS1, d);
		chk(d, 32'h555);
		ref_missing <= 1'b0;
		wr(ADDR_STATUS, 32'h4);
		rd(ADDR_STATUS, d);
		chk(d & 32'h4, 32'h0);
		$display("done reference loss");
		wr(ADDR_MODE, 32'h13);
		repeat (40) @(posedge core_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(ADDR_FILTER, d);
		chk(d, 32'h45);
		rd(ADDR_GAIN1, d);
		chk(d, 32'h42_0000);
		rd(ADDR_MODE, d);
		chk(d, 32'h0);
		$display("done reset");
		results();
	end
endmodule
`default_nettype wire
